// >>> shared/crf_pkg.sv
// Shared constants and enumerations of the core register and flag stack.
package crf_pkg;

    // ****************************************
    // Widths and depths
    // ****************************************
    localparam int DATA_W = 8; // Data path width
    localparam int PC_W = 12; // Program counter width
    localparam int STACK_DEPTH = 6; // Return stack levels
    localparam int DEPTH_W = 3; // Enough for 0..6
    localparam int PAGE_W = 8; // Program page register width

    // ****************************************
    // Data-space addresses
    // ****************************************
    localparam logic [7:0] ADDR_INDEX_FIRST = 8'h80;
    localparam logic [7:0] ADDR_INDEX_SECOND = 8'h81;
    localparam logic [7:0] ADDR_SHORT_FIRST = 8'h82;
    localparam logic [7:0] ADDR_SHORT_SECOND = 8'h83;
    localparam logic [7:0] ADDR_ACCUMULATOR = 8'hFF;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [11:0] RESET_VECTOR = 12'hFFE; // Reset vector location
    localparam logic [2:0] DEPTH_EMPTY = 3'h0; // Stack empty after reset
    localparam logic [7:0] PAGE_RESET = 8'h00; // Program page after reset

    // ****************************************
    // Timing counts
    // ****************************************
    localparam int CORE_DIV = 13; // Clock edges per core cycle
    localparam logic [3:0] CORE_DIV_LAST = 4'(CORE_DIV - 1);
    localparam int SHORT_ACCESS_CYCLES = 4; // Core cycles per short-direct access
    localparam logic [2:0] SHORT_ACCESS_LAST = 3'(SHORT_ACCESS_CYCLES - 1);

    // ****************************************
    // Enumerations
    // ****************************************
    // Execution contexts, each owning one flag pair
    typedef enum logic [1:0] {CTX_MAIN, CTX_IRQ, CTX_NMI} crf_ctx_type;

    // Program counter update sources
    typedef enum logic [3:0] {
        PC_HOLD, PC_INCR, PC_REL, PC_JUMP, PC_CALL, PC_IRQ, PC_NMI, PC_RET, PC_INTERRUPT_RETURN
    } crf_pc_op_type;

    // Flag-affecting operations
    typedef enum logic [2:0] {
        ALU_NONE, ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_RLC, ALU_BTEST, ALU_LOAD
    } crf_alu_op_type;

    // Short-direct access sequencer
    typedef enum logic {SD_IDLE, SD_BUSY} crf_sd_state_type;

endpackage : crf_pkg

// >>> rtl/crf_flag_pair.sv
// One carry/zero flag pair, updated only while its context is active.
`timescale 1ns/100ps
module crf_flag_pair (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Update strobes, already qualified by the active context
    input wire logic upd_carry,
    input wire logic carry_in,
    input wire logic upd_zero,
    input wire logic zero_in,
    // Held flag values
    output logic carry,
    output logic zero
);
    import crf_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic c; // Carry
        logic z; // Zero
    } crf_pair_state_type;

    crf_pair_state_type st_reg; // Registered pair
    crf_pair_state_type st_next; // Next pair

    // Pair holds its value through any context switch
    always_comb begin
        st_next = st_reg;
        if (!rst_n) begin
            // Defined start, software must not rely on it
            st_next = '0;
        end else begin
            if (upd_carry) begin
                st_next.c = carry_in;
            end
            if (upd_zero) begin
                st_next.z = zero_in;
            end
        end
    end

    // Register the pair
    always_ff @(posedge clk) begin
        st_reg <= st_next;
    end

    assign carry = st_reg.c;
    assign zero = st_reg.z;

endmodule : crf_flag_pair

// >>> rtl/crf_core_regs.sv
// Core register file: data registers, program counter, flag banks and return stack.
`timescale 1ns/100ps
module crf_core_regs (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Data-space bus
    input wire logic [7:0] data_addr,
    input wire logic data_wr,
    input wire logic [crf_pkg::DATA_W-1:0] data_wdata,
    input wire logic data_rd,
    output logic [crf_pkg::DATA_W-1:0] data_rdata,
    output logic data_hit,
    // Short-direct port
    input wire logic sd_req,
    input wire logic [1:0] sd_sel,
    input wire logic sd_write,
    input wire logic [crf_pkg::DATA_W-1:0] sd_wdata,
    output logic sd_busy,
    output logic sd_done,
    output logic [crf_pkg::DATA_W-1:0] sd_rdata,
    // Program counter control
    input wire crf_pkg::crf_pc_op_type pc_op,
    input wire logic [crf_pkg::PC_W-1:0] pc_target,
    input wire logic [7:0] pc_offset,
    input wire logic [crf_pkg::PC_W-1:0] int_vector,
    output logic [crf_pkg::PC_W-1:0] fetch_addr,
    output logic [crf_pkg::DEPTH_W-1:0] stack_depth,
    // Program page
    input wire logic page_wr,
    input wire logic [crf_pkg::PAGE_W-1:0] page_wdata,
    output logic [crf_pkg::PAGE_W-1:0] fetch_page,
    // Flag-affecting operation
    input wire crf_pkg::crf_alu_op_type alu_op,
    input wire logic [crf_pkg::DATA_W-1:0] alu_a,
    input wire logic [crf_pkg::DATA_W-1:0] alu_b,
    input wire logic [2:0] alu_bit,
    output logic [crf_pkg::DATA_W-1:0] alu_result,
    output logic carry_flag,
    output logic zero_flag,
    // Context and timing
    output crf_pkg::crf_ctx_type active_ctx,
    output logic core_tick
);
    import crf_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [DATA_W-1:0] acc; // Accumulator
        logic [DATA_W-1:0] idx_first; // First index pointer
        logic [DATA_W-1:0] idx_second; // Second index pointer
        logic [DATA_W-1:0] sd_first; // First short-direct register
        logic [DATA_W-1:0] sd_second; // Second short-direct register
        logic [PC_W-1:0] pc; // Program counter
        logic [STACK_DEPTH-1:0][PC_W-1:0] stk; // Return stack, level 0 on top
        logic [DEPTH_W-1:0] depth; // Filled levels
        crf_ctx_type ctx; // Active context
        crf_ctx_type ctx_before_irq; // Context to restore from interrupt
        crf_ctx_type ctx_before_nmi; // Context to restore from nonmaskable
        logic [PAGE_W-1:0] page; // Program page
        logic [3:0] div; // Core cycle divider
        logic tick; // Core cycle pulse
        crf_sd_state_type sd_state; // Short-direct sequencer
        logic [2:0] sd_cnt; // Core cycles spent
        logic [1:0] sd_sel; // Latched selector
        logic sd_write; // Latched direction
        logic [DATA_W-1:0] sd_wdata; // Latched write data
        logic sd_done; // Completion pulse
        logic [DATA_W-1:0] sd_rdata; // Short-direct read data
        logic [DATA_W-1:0] rdata; // Bus read data
        logic hit; // Bus read hit a register
        logic [DATA_W-1:0] alu_res; // Last operation result
    } crf_core_state_type;

    crf_core_state_type st_reg; // Registered state
    crf_core_state_type st_next; // Next state

    // ****************************************
    // Flag banks
    // ****************************************
    logic [2:0] bank_carry; // Carry per context
    logic [2:0] bank_zero; // Zero per context
    logic [2:0] bank_sel; // One-hot active context
    logic cur_carry; // Active carry
    logic upd_c; // Carry update request
    logic upd_z; // Zero update request
    logic new_c; // New carry
    logic new_z; // New zero
    logic [DATA_W-1:0] res; // Operation result
    logic [DATA_W:0] wide; // Result with carry out

    // Only the active context bank sees update strobes
    assign bank_sel = 3'(1) << st_reg.ctx;
    assign cur_carry = bank_carry[st_reg.ctx];

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_bank
            crf_flag_pair u_pair (
                .clk(clk),
                .rst_n(rst_n),
                .upd_carry(upd_c & bank_sel[g]),
                .carry_in(new_c),
                .upd_zero(upd_z & bank_sel[g]),
                .zero_in(new_z),
                .carry(bank_carry[g]),
                .zero(bank_zero[g])
            );
        end
    endgenerate

    // ****************************************
    // Flag-affecting operations
    // ****************************************
    // Carry and zero from the operation in flight
    always_comb begin
        wide = '0;
        res = alu_a;
        upd_c = 1'b0;
        upd_z = 1'b0;
        new_c = 1'b0;
        case (alu_op)
            ALU_ADD: begin
                wide = {1'b0, alu_a} + {1'b0, alu_b};
                res = wide[DATA_W-1:0];
                new_c = wide[DATA_W];
                upd_c = 1'b1;
                upd_z = 1'b1;
            end
            ALU_SUB: begin
                wide = {1'b0, alu_a} - {1'b0, alu_b};
                res = wide[DATA_W-1:0];
                new_c = wide[DATA_W];
                upd_c = 1'b1;
                upd_z = 1'b1;
            end
            ALU_AND: begin
                res = alu_a & alu_b;
                upd_z = 1'b1;
            end
            ALU_OR: begin
                res = alu_a | alu_b;
                upd_z = 1'b1;
            end
            ALU_RLC: begin
                // Old carry enters bit 0, bit 7 leaves into carry
                res = {alu_a[DATA_W-2:0], cur_carry};
                new_c = alu_a[DATA_W-1];
                upd_c = 1'b1;
                upd_z = 1'b1;
            end
            ALU_BTEST: begin
                new_c = alu_a[alu_bit];
                upd_c = 1'b1;
            end
            ALU_LOAD: begin
                upd_z = 1'b1;
            end
            default: begin
                upd_c = 1'b0;
            end
        endcase
        new_z = (res == '0);
    end

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        st_next = st_reg;
        st_next.sd_done = 1'b0;
        st_next.hit = 1'b0;
        st_next.tick = 1'b0;

        // Core cycle divider
        if (st_reg.div == CORE_DIV_LAST) begin
            st_next.div = '0;
            st_next.tick = 1'b1;
        end else begin
            st_next.div = st_reg.div + 4'h1;
        end

        // Data-space writes
        if (data_wr) begin
            case (data_addr)
                ADDR_ACCUMULATOR: st_next.acc = data_wdata;
                ADDR_INDEX_FIRST: st_next.idx_first = data_wdata;
                ADDR_INDEX_SECOND: st_next.idx_second = data_wdata;
                ADDR_SHORT_FIRST: st_next.sd_first = data_wdata;
                ADDR_SHORT_SECOND: st_next.sd_second = data_wdata;
                default: st_next.hit = 1'b0;
            endcase
        end

        // Data-space reads, one cycle latency
        if (data_rd) begin
            st_next.hit = 1'b1;
            case (data_addr)
                ADDR_ACCUMULATOR: st_next.rdata = st_reg.acc;
                ADDR_INDEX_FIRST: st_next.rdata = st_reg.idx_first;
                ADDR_INDEX_SECOND: st_next.rdata = st_reg.idx_second;
                ADDR_SHORT_FIRST: st_next.rdata = st_reg.sd_first;
                ADDR_SHORT_SECOND: st_next.rdata = st_reg.sd_second;
                default: begin
                    st_next.rdata = '0;
                    st_next.hit = 1'b0;
                end
            endcase
        end

        // Short-direct access: index pointers share the compact form
        case (st_reg.sd_state)
            SD_IDLE: begin
                if (sd_req) begin
                    st_next.sd_state = SD_BUSY;
                    st_next.sd_cnt = '0;
                    st_next.sd_sel = sd_sel;
                    st_next.sd_write = sd_write;
                    st_next.sd_wdata = sd_wdata;
                end
            end
            SD_BUSY: begin
                if (st_reg.tick) begin
                    if (st_reg.sd_cnt == SHORT_ACCESS_LAST) begin
                        st_next.sd_state = SD_IDLE;
                        st_next.sd_done = 1'b1;
                        case (st_reg.sd_sel)
                            2'h0: st_next.sd_rdata = st_reg.idx_first;
                            2'h1: st_next.sd_rdata = st_reg.idx_second;
                            2'h2: st_next.sd_rdata = st_reg.sd_first;
                            default: st_next.sd_rdata = st_reg.sd_second;
                        endcase
                        if (st_reg.sd_write) begin
                            // Completed access overrides a same-cycle bus write
                            case (st_reg.sd_sel)
                                2'h0: st_next.idx_first = st_reg.sd_wdata;
                                2'h1: st_next.idx_second = st_reg.sd_wdata;
                                2'h2: st_next.sd_first = st_reg.sd_wdata;
                                default: st_next.sd_second = st_reg.sd_wdata;
                            endcase
                            st_next.sd_rdata = st_reg.sd_wdata;
                        end
                    end else begin
                        st_next.sd_cnt = st_reg.sd_cnt + 3'h1;
                    end
                end
            end
            default: st_next.sd_state = SD_IDLE;
        endcase

        // Operation result
        if (alu_op != ALU_NONE) begin
            st_next.alu_res = res;
        end

        // Program page, counter itself stays twelve bits
        if (page_wr) begin
            st_next.page = page_wdata;
        end

        // Program counter and return stack
        case (pc_op)
            PC_INCR: st_next.pc = st_reg.pc + 12'h001;
            PC_REL: st_next.pc = st_reg.pc + {{4{pc_offset[7]}}, pc_offset};
            PC_JUMP: st_next.pc = pc_target;
            PC_CALL, PC_IRQ, PC_NMI: begin
                // Shift every level down, bottom falls off
                st_next.stk = {st_reg.stk[STACK_DEPTH-2:0], st_reg.pc};
                if (st_reg.depth != 3'(STACK_DEPTH)) begin
                    st_next.depth = st_reg.depth + 3'h1;
                end
                if (pc_op == PC_CALL) begin
                    st_next.pc = pc_target;
                end else begin
                    st_next.pc = int_vector;
                end
                if (pc_op == PC_IRQ) begin
                    st_next.ctx = CTX_IRQ;
                    st_next.ctx_before_irq = st_reg.ctx;
                end
                if (pc_op == PC_NMI) begin
                    st_next.ctx = CTX_NMI;
                    st_next.ctx_before_nmi = st_reg.ctx;
                end
            end
            PC_RET, PC_INTERRUPT_RETURN: begin
                if (st_reg.depth != DEPTH_EMPTY) begin
                    st_next.pc = st_reg.stk[0];
                    st_next.stk = {st_reg.stk[STACK_DEPTH-1], st_reg.stk[STACK_DEPTH-1:1]};
                    st_next.depth = st_reg.depth - 3'h1;
                end else begin
                    // Empty stack: carry on with the next location
                    st_next.pc = st_reg.pc + 12'h001;
                end
                if (pc_op == PC_INTERRUPT_RETURN) begin
                    case (st_reg.ctx)
                        CTX_NMI: st_next.ctx = st_reg.ctx_before_nmi;
                        CTX_IRQ: st_next.ctx = st_reg.ctx_before_irq;
                        default: st_next.ctx = CTX_MAIN;
                    endcase
                end
            end
            default: st_next.pc = st_reg.pc;
        endcase

        // Reset loads control state and clears read data and result; data registers keep garbage
        if (!rst_n) begin
            st_next.pc = RESET_VECTOR;
            st_next.depth = DEPTH_EMPTY;
            st_next.ctx = CTX_NMI;
            st_next.ctx_before_irq = CTX_MAIN;
            st_next.ctx_before_nmi = CTX_MAIN;
            st_next.page = PAGE_RESET;
            st_next.div = '0;
            st_next.tick = 1'b0;
            st_next.sd_state = SD_IDLE;
            st_next.sd_cnt = '0;
            st_next.sd_done = 1'b0;
            st_next.sd_rdata = '0;
            st_next.rdata = '0;
            st_next.hit = 1'b0;
            st_next.alu_res = '0;
        end
    end

    // Register the whole state
    always_ff @(posedge clk) begin
        st_reg <= st_next;
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign data_rdata = st_reg.rdata;
    assign data_hit = st_reg.hit;
    assign sd_busy = (st_reg.sd_state == SD_BUSY);
    assign sd_done = st_reg.sd_done;
    assign sd_rdata = st_reg.sd_rdata;
    assign fetch_addr = st_reg.pc;
    assign stack_depth = st_reg.depth;
    assign fetch_page = st_reg.page;
    assign alu_result = st_reg.alu_res;
    assign carry_flag = bank_carry[st_reg.ctx];
    assign zero_flag = bank_zero[st_reg.ctx];
    assign active_ctx = st_reg.ctx;
    assign core_tick = st_reg.tick;

endmodule : crf_core_regs

// >>> tb/crf_bus_agent.sv
// Data-space bus agent standing in for the memory side of the core.
`timescale 1ns/100ps
module crf_bus_agent (
    // Clock
    input wire logic clk,
    // Bus towards the register file
    output logic [7:0] data_addr,
    output logic data_wr,
    output logic [7:0] data_wdata,
    output logic data_rd,
    input wire logic [7:0] data_rdata,
    input wire logic data_hit
);
    // Idle bus with both strobes low
    initial begin
        data_addr = 8'h00;
        data_wr = 1'b0;
        data_wdata = 8'h00;
        data_rd = 1'b0;
    end
    // One-cycle write, launched and released on falling edges
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        data_addr = a;
        data_wdata = d;
        data_wr = 1'b1;
        @(negedge clk);
        data_wr = 1'b0;
        data_wdata = ~d; // Stale data is scrambled so nobody relies on it
    endtask : write
    // One-cycle read; the answer is taken one edge later
    task automatic read(input logic [7:0] a, output logic [7:0] d, output logic h);
        @(negedge clk);
        data_addr = a;
        data_rd = 1'b1;
        @(negedge clk);
        data_rd = 1'b0;
        d = data_rdata;
        h = data_hit;
    endtask : read
endmodule : crf_bus_agent

// >>> tb/crf_core_regs_properties.sv
// Concurrent checks on the core register file ports.
`timescale 1ns/100ps
module crf_core_regs_properties (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Program counter and stack
    input wire crf_pkg::crf_pc_op_type pc_op,
    input wire logic [11:0] pc_target,
    input wire logic [7:0] pc_offset,
    input wire logic [11:0] int_vector,
    input wire logic [11:0] fetch_addr,
    input wire logic [2:0] stack_depth,
    input wire crf_pkg::crf_ctx_type active_ctx,
    // Flags and timing
    input wire crf_pkg::crf_alu_op_type alu_op,
    input wire logic [7:0] alu_a,
    input wire logic [7:0] alu_b,
    input wire logic carry_flag,
    input wire logic [7:0] alu_result,
    input wire logic core_tick,
    input wire logic sd_busy,
    input wire logic sd_done,
    // Data bus
    input wire logic [7:0] data_addr,
    input wire logic data_rd,
    input wire logic data_hit
);
    import crf_pkg::*;
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_incr; pc_op == PC_INCR |=> fetch_addr == $past(fetch_addr) + 12'h001; endproperty
    a_incr: assert property (p_incr) else $error("pc did not advance by one");
    property p_rel; pc_op == PC_REL |=> fetch_addr == $past(fetch_addr) + 12'($signed($past(pc_offset))); endproperty
    a_rel: assert property (p_rel) else $error("relative branch sum wrong");
    property p_jump; pc_op inside {PC_JUMP, PC_CALL} |=> fetch_addr == $past(pc_target); endproperty
    a_jump: assert property (p_jump) else $error("jump target not loaded");
    property p_vec; pc_op inside {PC_IRQ, PC_NMI} |=> fetch_addr == $past(int_vector); endproperty
    a_vec: assert property (p_vec) else $error("vector not loaded");
    property p_push; pc_op == PC_CALL |=> stack_depth == ($past(stack_depth) == 3'h6 ? 3'h6 : $past(stack_depth) + 3'h1);
    endproperty
    a_push: assert property (p_push) else $error("stack depth wrong after call");
    property p_empty; pc_op == PC_RET && stack_depth == 3'h0 |=> stack_depth == 3'h0 && $changed(fetch_addr); endproperty
    a_empty: assert property (p_empty) else $error("empty return misbehaved");
    property p_ctx; pc_op == PC_IRQ |=> active_ctx == CTX_IRQ; endproperty
    a_ctx: assert property (p_ctx) else $error("interrupt context not entered");
    property p_add; alu_op == ALU_ADD && pc_op inside {PC_HOLD, PC_INCR}
        |=> {carry_flag, alu_result} == {1'b0, $past(alu_a)} + {1'b0, $past(alu_b)}; endproperty
    a_add: assert property (p_add) else $error("add carry or result wrong");
    property p_short; $rose(sd_busy) |-> ##[40:53] sd_done; endproperty
    a_short: assert property (p_short) else $error("short access too slow");
    property p_tick; core_tick |-> ##13 core_tick; endproperty
    a_tick: assert property (p_tick) else $error("core cycle spacing wrong");
    property p_hit; data_rd |=> data_hit == ($past(data_addr) inside {8'h80, 8'h81, 8'h82, 8'h83, 8'hFF}); endproperty
    a_hit: assert property (p_hit) else $error("data hit wrong");
endmodule : crf_core_regs_properties
bind crf_core_regs crf_core_regs_properties i_crf_core_regs_properties (.*);

// >>> tb/cpu_register_flag_stack_tb.sv
// Self-checking bench for the core register file.
`timescale 1ns/100ps
module cpu_register_flag_stack_tb;
    import crf_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, data_wr, data_rd, data_hit, sd_req = 1'b0, sd_write = 1'b0, sd_busy, sd_done;
    logic [7:0] data_addr, data_wdata, data_rdata, sd_wdata = 8'h00, sd_rdata, alu_result, rd, v;
    logic [7:0] pc_offset = 8'h00, page_wdata = 8'h00, fetch_page, alu_a = 8'h00, alu_b = 8'h00, vals[4], ad;
    logic [7:0] offs[4] = '{8'h05, 8'h80, 8'h7F, 8'hF0};
    crf_alu_op_type ops[5] = '{ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_LOAD};
    logic [1:0] sd_sel = 2'h0;
    logic [2:0] stack_depth, alu_bit = 3'h0;
    logic [11:0] pc_target = 12'h000, int_vector = 12'h000, fetch_addr, e, q[$];
    logic page_wr = 1'b0, carry_flag, zero_flag, core_tick, h;
    crf_pc_op_type pc_op = PC_HOLD;
    crf_alu_op_type alu_op = ALU_NONE;
    crf_ctx_type active_ctx;
    int failures = 0, check_count = 0, n;
    // Free-running 40 MHz clock
    always #12.5 clk = ~clk;
    crf_bus_agent i_crf_bus_agent (.*);
    crf_core_regs i_crf_core_regs (.*);
    // ****************************************
    // Helpers
    // ****************************************
    // Single comparison point, four-state exact
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check
    // One program counter operation, then back to hold
    task automatic pc_step(input crf_pc_op_type op, input logic [11:0] t);
        @(negedge clk);
        pc_op = op;
        pc_target = t;
        int_vector = t;
        pc_offset = t[7:0];
        @(negedge clk);
        pc_op = PC_HOLD;
    endtask : pc_step
    // One flag-affecting operation, then back to none
    task automatic alu_step(input crf_alu_op_type op, input logic [7:0] a, input logic [7:0] b);
        @(negedge clk);
        alu_op = op;
        alu_a = a;
        alu_b = b;
        alu_bit = b[2:0];
        @(negedge clk);
        alu_op = ALU_NONE;
    endtask : alu_step
    // Expected carry, zero and result; logic ops and load keep the old carry
    function automatic logic [9:0] alu_exp(input crf_alu_op_type op, input logic [7:0] a, b, input logic c);
        logic [8:0] s;
        s = op == ALU_ADD ? {1'b0, a} + {1'b0, b} : op == ALU_SUB ? {1'b0, a} - {1'b0, b} :
            op == ALU_AND ? {c, a & b} : op == ALU_OR ? {c, a | b} : {c, a};
        return {s[8], s[7:0] == 8'h00, s[7:0]};
    endfunction : alu_exp
    // Verdict and end of run
    task automatic print_verdict();
        $display("failures %0d check_count %0d", failures, check_count);
        if (failures == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : print_verdict
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        void'($urandom(21828));
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        check({active_ctx, stack_depth, fetch_addr}, {CTX_NMI, 3'h0, 12'hFFE}, "after reset");
        for (int i = 0; i < 6; i++) begin
            v = 8'($urandom);
            ad = i < 4 ? 8'h80 + 8'(i) : i == 4 ? 8'hFF : 8'h84;
            i_crf_bus_agent.write(ad, v);
            i_crf_bus_agent.read(ad, rd, h);
            check({h, rd}, i < 5 ? {1'b1, v} : 9'h000, "data space");
        end
        // Short-direct writes to all four, then reads back in reverse
        for (int i = 0; i < 8; i++) begin
            @(negedge clk);
            sd_req = 1'b1;
            sd_sel = i < 4 ? 2'(i) : 2'(7 - i);
            sd_write = i < 4;
            sd_wdata = 8'($urandom);
            if (i < 4) vals[i] = sd_wdata;
            @(negedge clk);
            sd_req = 1'b0;
            n = 1;
            while (sd_done !== 1'b1 && n < 60) begin
                @(negedge clk);
                n++;
            end
            check(16'(n >= 40 && n <= 53), 16'h1, "short access time");
            check(sd_rdata, vals[sd_sel], "short access data");
        end
        i_crf_bus_agent.read(8'h82, rd, h);
        check(rd, vals[2], "short reg via bus");
        // Seven calls overflow the six-level stack
        for (int i = 0; i < 7; i++) begin
            q.push_front(fetch_addr);
            if (q.size() > 6) void'(q.pop_back());
            e = 12'($urandom);
            pc_step(PC_CALL, e);
            check(fetch_addr, e, "call target");
        end
        check(stack_depth, 3'h6, "saturated depth");
        for (int i = 0; i < 6; i++) begin
            pc_step(PC_RET, 12'h000);
            check(fetch_addr, q.pop_front(), "return address");
        end
        e = fetch_addr + 12'h001;
        pc_step(PC_RET, 12'h000);
        check({stack_depth, fetch_addr}, {3'h0, e}, "empty return");
        foreach (offs[i]) begin
            e = fetch_addr + 12'($signed(offs[i]));
            pc_step(PC_REL, {4'h0, offs[i]});
            check(fetch_addr, e, "relative branch");
        end
        e = fetch_addr + 12'h001;
        pc_step(PC_INCR, 12'h000);
        check(fetch_addr, e, "increment");
        @(negedge clk);
        page_wr = 1'b1;
        page_wdata = 8'($urandom);
        @(negedge clk);
        page_wr = 1'b0;
        check(fetch_page, page_wdata, "page register");
        // Flag pairs across context switches
        alu_step(ALU_ADD, 8'hFF, 8'h01);
        check({carry_flag, zero_flag, alu_result}, 10'h300, "nmi pair add");
        pc_step(PC_IRQ, 12'hFF0);
        check({active_ctx, carry_flag, zero_flag}, {CTX_IRQ, 2'b00}, "irq pair fresh");
        for (int i = 0; i < 20; i++) begin
            alu_a = 8'($urandom);
            alu_b = i == 1 ? alu_a : 8'($urandom);
            h = carry_flag;
            alu_step(ops[i % 5], alu_a, alu_b);
            check({carry_flag, zero_flag, alu_result}, alu_exp(ops[i % 5], alu_a, alu_b, h), "alu");
        end
        v = 8'($urandom);
        h = zero_flag;
        alu_step(ALU_BTEST, v, 8'h05);
        check({carry_flag, zero_flag}, {v[5], h}, "bit test");
        alu_step(ALU_RLC, v, 8'h00);
        check({carry_flag, alu_result}, {v[7], v[6:0], v[5]}, "rotate");
        pc_step(PC_INTERRUPT_RETURN, 12'h000);
        check({active_ctx, carry_flag, zero_flag}, {CTX_NMI, 2'b11}, "nmi pair kept");
        pc_step(PC_INTERRUPT_RETURN, 12'h000);
        check({active_ctx, carry_flag, zero_flag}, {CTX_MAIN, 2'b00}, "main pair");
        pc_step(PC_NMI, 12'hFFC);
        check({active_ctx, carry_flag, zero_flag, fetch_addr}, {CTX_NMI, 2'b11, 12'hFFC}, "nmi reentry");
        print_verdict();
    end
endmodule : cpu_register_flag_stack_tb
